// ---- rtl/csw_pkg.sv ----
package csw_pkg;

  // ****************************************
  // clock sources and fields
  // ****************************************
  localparam int SRC_W = 3;
  localparam int DIV_W = 4;
  localparam int FRQ_W = 4;
  localparam int SRC_COUNT = 6;
  typedef logic [SRC_W-1:0] csw_src_t;
  typedef logic [DIV_W-1:0] csw_div_t;
  typedef logic [FRQ_W-1:0] csw_frq_t;

  localparam csw_src_t SRC_EXT = 3'h0;
  localparam csw_src_t SRC_FAST = 3'h1;
  localparam csw_src_t SRC_SLOW = 3'h2;
  localparam csw_src_t SRC_SECONDARY = 3'h3;
  localparam csw_src_t SRC_EXT_PLL4 = 3'h4;
  localparam csw_src_t SRC_FAST_PLL2 = 3'h5;

  localparam csw_src_t SRC_RESET = SRC_FAST;
  localparam csw_div_t DIV_RESET = 4'h0;
  localparam csw_frq_t FRQ_RESET = 4'h0;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADR_WORD_MASK = 8'hFC;
  localparam logic [7:0] REG_REQ = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_FLAG = 8'h0C;
  localparam logic [7:0] REG_FREQ = 8'h10;

  localparam int REQ_SRC_LSB = 0;
  localparam int REQ_DIV_LSB = 4;
  localparam int CTL_HOLD = 0;
  localparam int CTL_IE = 1;
  localparam int CTL_REDUCED_CPU_RATE_MODE = 2;
  localparam int ST_SRC_LSB = 0;
  localparam int ST_DIV_LSB = 4;
  localparam int ST_NEW_RDY = 8;
  localparam int ST_OSC_RDY = 9;
  localparam int ST_FRDY = 10;
  localparam int ST_MRDY = 11;
  localparam int FLAG_SW = 0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 8;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_READY = 5'h04,
    ST_GATE = 5'h08,
    ST_SWAP = 5'h10
  } csw_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } csw_wb_req_s;

  typedef struct packed {
    logic wr;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } csw_reg_wr_s;

endpackage

// ---- rtl/csw_wb_slave.sv ----
`timescale 1ns/1ps
module csw_wb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input csw_pkg::csw_wb_req_s req,
  input wire logic [31:0] rdata,
  output logic ack,
  output logic [31:0] dat,
  output csw_pkg::csw_reg_wr_s wr
);

  logic ack_q;
  logic [31:0] dat_q;

  // ****************************************
  // one wait state, ack for one cycle
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req.cyc && req.stb && !ack_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= 32'h00000000;
    end else if (req.cyc && req.stb && !ack_q) begin
      dat_q <= rdata;
    end
  end

  // write lands on the edge where the master sees ack
  assign wr.wr = req.cyc && req.stb && req.we && ack_q;
  assign wr.adr = req.adr;
  assign wr.sel = req.sel;
  assign wr.dat = req.dat;
  assign ack = ack_q;
  assign dat = dat_q;

endmodule

// ---- rtl/csw_ready_filter.sv ----
`timescale 1ns/1ps
module csw_ready_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic lock,
  output logic ready
);

  logic [csw_pkg::SETTLE_W-1:0] cnt_q;
  logic ready_q;

  // ****************************************
  // settle count after each frequency load
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (restart) begin
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      if (!lock) begin
        cnt_q <= '0;
      end else if (cnt_q == csw_pkg::SETTLE_LAST) begin
        ready_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign ready = ready_q;

endmodule

// ---- rtl/csw_switch_ctrl.sv ----
`timescale 1ns/1ps
module csw_switch_ctrl (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [5:0] OSC_STABLE,
  input wire logic FAST_LOCK,
  input wire logic MID_LOCK,
  input wire logic CPU_CYCLE,
  input wire logic SLEEP_REQ,
  output logic SLEEP_ACK,
  output logic [2:0] SRC_SEL,
  output logic [3:0] DIV_SEL,
  output logic [3:0] FREQ_SEL,
  output logic CLK_GATE_EN,
  output logic MID_CLK_STALL,
  output logic SWITCH_IRQ
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return (adr & csw_pkg::ADR_WORD_MASK) == off;
  endfunction

  function automatic logic src_ready(input csw_pkg::csw_src_t src, input logic [5:0] stable);
    return (int'(src) < csw_pkg::SRC_COUNT) && stable[src];
  endfunction

  csw_pkg::csw_wb_req_s bus_req;
  csw_pkg::csw_reg_wr_s wr;
  logic [31:0] rdata;
  logic wr_req;
  logic wr_ctrl;
  logic wr_flag;
  logic wr_freq;
  logic wr_req_ok;
  logic match_cur;
  logic rdy_now;
  logic ready_evt;
  csw_pkg::csw_src_t new_src;
  csw_pkg::csw_div_t new_div;
  csw_pkg::csw_src_t req_src_q;
  csw_pkg::csw_div_t req_div_q;
  csw_pkg::csw_src_t cur_src_q;
  csw_pkg::csw_div_t cur_div_q;
  csw_pkg::csw_frq_t freq_q;
  csw_pkg::csw_state_e state_q;
  logic hold_q;
  logic ie_q;
  logic reduced_cpu_rate_mode_q;
  logic flag_q;
  logic new_rdy_q;
  logic gate_q;
  logic sleep_q;
  logic [1:0] lock_vec;
  logic [1:0] rdy_vec;

  // ****************************************
  // bus slave
  // ****************************************
  assign bus_req.cyc = WB_CYC_I;
  assign bus_req.stb = WB_STB_I;
  assign bus_req.we = WB_WE_I;
  assign bus_req.adr = WB_ADR_I;
  assign bus_req.sel = WB_SEL_I;
  assign bus_req.dat = WB_DAT_I;

  csw_wb_slave u_slave (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .req(bus_req),
    .rdata(rdata),
    .ack(WB_ACK_O),
    .dat(WB_DAT_O),
    .wr(wr)
  );

  assign wr_req = wr.wr && wr.sel[0] && hit(wr.adr, csw_pkg::REG_REQ);
  assign wr_ctrl = wr.wr && wr.sel[0] && hit(wr.adr, csw_pkg::REG_CTRL);
  assign wr_flag = wr.wr && wr.sel[0] && hit(wr.adr, csw_pkg::REG_FLAG);
  assign wr_freq = wr.wr && wr.sel[0] && hit(wr.adr, csw_pkg::REG_FREQ);

  // request writes are refused while the mux is being swapped
  assign wr_req_ok = wr_req && (state_q inside {csw_pkg::ST_IDLE, csw_pkg::ST_WAIT, csw_pkg::ST_READY});
  assign new_src = wr.dat[csw_pkg::REQ_SRC_LSB +: csw_pkg::SRC_W];
  assign new_div = wr.dat[csw_pkg::REQ_DIV_LSB +: csw_pkg::DIV_W];
  assign match_cur = (new_src == cur_src_q) && (new_div == cur_div_q);

  always_comb begin
    rdata = 32'h00000000;
    if (hit(WB_ADR_I, csw_pkg::REG_REQ)) begin
      rdata[csw_pkg::REQ_SRC_LSB +: csw_pkg::SRC_W] = req_src_q;
      rdata[csw_pkg::REQ_DIV_LSB +: csw_pkg::DIV_W] = req_div_q;
    end else if (hit(WB_ADR_I, csw_pkg::REG_CTRL)) begin
      rdata[csw_pkg::CTL_HOLD] = hold_q;
      rdata[csw_pkg::CTL_IE] = ie_q;
      rdata[csw_pkg::CTL_REDUCED_CPU_RATE_MODE] = reduced_cpu_rate_mode_q;
    end else if (hit(WB_ADR_I, csw_pkg::REG_STAT)) begin
      rdata[csw_pkg::ST_SRC_LSB +: csw_pkg::SRC_W] = cur_src_q;
      rdata[csw_pkg::ST_DIV_LSB +: csw_pkg::DIV_W] = cur_div_q;
      rdata[csw_pkg::ST_NEW_RDY] = new_rdy_q;
      rdata[csw_pkg::ST_OSC_RDY] = new_rdy_q || (state_q == csw_pkg::ST_IDLE);
      rdata[csw_pkg::ST_FRDY] = rdy_vec[0];
      rdata[csw_pkg::ST_MRDY] = rdy_vec[1];
    end else if (hit(WB_ADR_I, csw_pkg::REG_FLAG)) begin
      rdata[csw_pkg::FLAG_SW] = flag_q;
    end else if (hit(WB_ADR_I, csw_pkg::REG_FREQ)) begin
      rdata[csw_pkg::FRQ_W-1:0] = freq_q;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      req_src_q <= csw_pkg::SRC_RESET;
      req_div_q <= csw_pkg::DIV_RESET;
    end else if (wr_req_ok) begin
      req_src_q <= new_src;
      req_div_q <= new_div;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      hold_q <= 1'b0;
      ie_q <= 1'b0;
      reduced_cpu_rate_mode_q <= 1'b0;
    end else if (wr_ctrl) begin
      hold_q <= wr.dat[csw_pkg::CTL_HOLD];
      ie_q <= wr.dat[csw_pkg::CTL_IE];
      reduced_cpu_rate_mode_q <= wr.dat[csw_pkg::CTL_REDUCED_CPU_RATE_MODE];
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      freq_q <= csw_pkg::FRQ_RESET;
    end else if (wr_freq) begin
      freq_q <= wr.dat[csw_pkg::FRQ_W-1:0];
    end
  end

  // ****************************************
  // internal oscillator ready flags
  // ****************************************
  assign lock_vec = {MID_LOCK, FAST_LOCK};

  for (genvar g = 0; g < 2; g++) begin : g_int_rdy
    csw_ready_filter u_filt (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .restart(wr_freq),
      .lock(lock_vec[g]),
      .ready(rdy_vec[g])
    );
  end

  assign MID_CLK_STALL = !rdy_vec[0];

  // ****************************************
  // switch sequencer
  // ****************************************
  assign rdy_now = (req_src_q == cur_src_q) || src_ready(req_src_q, OSC_STABLE);
  assign ready_evt = (state_q == csw_pkg::ST_WAIT) && !wr_req_ok && rdy_now;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= csw_pkg::ST_IDLE;
    end else begin
      case (state_q)
        csw_pkg::ST_IDLE: begin
          if (wr_req_ok && !match_cur) begin
            state_q <= csw_pkg::ST_WAIT;
          end
        end
        csw_pkg::ST_WAIT: begin
          if (wr_req_ok && match_cur) begin
            state_q <= csw_pkg::ST_IDLE;
          end else if (ready_evt) begin
            state_q <= csw_pkg::ST_READY;
          end
        end
        csw_pkg::ST_READY: begin
          if (wr_req_ok && match_cur) begin
            state_q <= csw_pkg::ST_IDLE;
          end else if (wr_req_ok) begin
            state_q <= csw_pkg::ST_WAIT;
          end else if (!hold_q && (reduced_cpu_rate_mode_q || CPU_CYCLE)) begin
            state_q <= csw_pkg::ST_GATE;
          end
        end
        csw_pkg::ST_GATE: begin
          state_q <= csw_pkg::ST_SWAP;
        end
        csw_pkg::ST_SWAP: begin
          state_q <= csw_pkg::ST_IDLE;
        end
        default: begin
          state_q <= csw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // gate off before the select moves, back on a cycle after
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      gate_q <= 1'b1;
    end else if (state_q == csw_pkg::ST_READY && !wr_req_ok && !hold_q && (reduced_cpu_rate_mode_q || CPU_CYCLE)) begin
      gate_q <= 1'b0;
    end else if (state_q == csw_pkg::ST_SWAP) begin
      gate_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cur_src_q <= csw_pkg::SRC_RESET;
      cur_div_q <= csw_pkg::DIV_RESET;
    end else if (state_q == csw_pkg::ST_GATE) begin
      cur_src_q <= req_src_q;
      cur_div_q <= req_div_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      new_rdy_q <= 1'b0;
    end else if (ready_evt) begin
      new_rdy_q <= 1'b1;
    end else if (wr_req_ok || state_q == csw_pkg::ST_SWAP) begin
      new_rdy_q <= 1'b0;
    end
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      flag_q <= 1'b0;
    end else if (ready_evt) begin
      flag_q <= 1'b1;
    end else if (wr_flag && wr.dat[csw_pkg::FLAG_SW]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= SLEEP_REQ;
    end
  end

  assign SWITCH_IRQ = flag_q && ie_q;
  assign SLEEP_ACK = sleep_q;
  assign SRC_SEL = cur_src_q;
  assign DIV_SEL = cur_div_q;
  assign FREQ_SEL = freq_q;
  assign CLK_GATE_EN = gate_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  freq_clear_a: assert property (wr_freq |=> !rdy_vec[0] && !rdy_vec[1] && MID_CLK_STALL)
    else $error("ready flags not cleared by frequency load");
  mid_stall_a: assert property (MID_CLK_STALL && !FAST_LOCK |=> MID_CLK_STALL)
    else $error("mid clock stall ended before fast oscillator resumed");
  old_clock_a: assert property (state_q == csw_pkg::ST_WAIT |=> $stable(SRC_SEL) && CLK_GATE_EN)
    else $error("clock moved while waiting for new source");
  same_src_a: assert property (state_q == csw_pkg::ST_WAIT && !wr_req_ok && req_src_q == cur_src_q
    |=> new_rdy_q)
    else $error("running source not ready at once");
  sleep_ok_a: assert property (SLEEP_REQ |=> SLEEP_ACK)
    else $error("sleep refused");
  ready_pair_a: assert property ($rose(new_rdy_q) |-> flag_q && $past(state_q) == csw_pkg::ST_WAIT)
    else $error("ready bit without switch flag");
  irq_gate_a: assert property (ready_evt && ie_q && !wr_ctrl |=> SWITCH_IRQ)
    else $error("interrupt missing when new source ready");
  auto_switch_a: assert property (state_q == csw_pkg::ST_READY && !wr_req_ok && !hold_q && reduced_cpu_rate_mode_q
    |=> !CLK_GATE_EN ##1 (SRC_SEL == $past(req_src_q, 2)) ##1 CLK_GATE_EN)
    else $error("switch did not complete after ready");
  hold_keep_a: assert property (state_q == csw_pkg::ST_READY && hold_q |=> $stable(SRC_SEL))
    else $error("held switch changed clock");
  cancel_a: assert property (wr_req_ok && match_cur && state_q != csw_pkg::ST_IDLE
    |=> state_q == csw_pkg::ST_IDLE && !new_rdy_q)
    else $error("cancel did not abandon switch");
  runt_free_a: assert property (SRC_SEL != $past(SRC_SEL) |-> !CLK_GATE_EN && !$past(CLK_GATE_EN))
    else $error("select moved while clock gated on");

  held_done_c: cover property (state_q == csw_pkg::ST_READY && hold_q ##[1:50] state_q == csw_pkg::ST_GATE);
  cancel_c: cover property (state_q == csw_pkg::ST_READY && wr_req_ok && match_cur);
  div_only_c: cover property (state_q == csw_pkg::ST_SWAP && SRC_SEL == $past(SRC_SEL) && DIV_SEL != $past(DIV_SEL));

endmodule

// ---- test/csw_switch_ctrl_bench.sv ----
`timescale 1ns/1ps
module csw_switch_ctrl_bench;
  `define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end

  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack;
  logic [5:0] osc_stable = 6'h00;
  logic fast_lock = 1'b0;
  logic mid_lock = 1'b0;
  logic cpu_cycle = 1'b0;
  logic sleep_req = 1'b0;
  logic sleep_ack, gate_en, mid_stall, irq;
  logic [2:0] src_sel;
  logic [3:0] div_sel, freq_sel;
  logic [31:0] rd;
  logic [2:0] src_list [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
  int err_total = 0;
  int cmp_count = 0;

  always #4 sys_clk = ~sys_clk;

  csw_switch_ctrl dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack),
    .OSC_STABLE(osc_stable), .FAST_LOCK(fast_lock), .MID_LOCK(mid_lock), .CPU_CYCLE(cpu_cycle),
    .SLEEP_REQ(sleep_req), .SLEEP_ACK(sleep_ack), .SRC_SEL(src_sel), .DIV_SEL(div_sel),
    .FREQ_SEL(freq_sel), .CLK_GATE_EN(gate_en), .MID_CLK_STALL(mid_stall), .SWITCH_IRQ(irq)
  );

  // ****************************************
  // bus access
  // ****************************************
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    `CHK("ack", 1'b1, wb_ack)
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(1'b1, adr, dat);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] ex);
    wb_cycle(1'b0, adr, 32'h0);
    `CHK(nm, ex, rd & msk)
  endtask

  task automatic wait_src(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (src_sel !== s && n < 40);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    fast_lock <= 1'b1;
    mid_lock <= 1'b1;
    @(negedge sys_clk);
    `CHK("src_sel", csw_pkg::SRC_FAST, src_sel)
    `CHK("div_sel", 4'h0, div_sel)
    `CHK("gate_en", 1'b1, gate_en)
    `CHK("mid_stall", 1'b1, mid_stall)
    `CHK("irq", 1'b0, irq)
    rd_chk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");

    repeat (130) @(posedge sys_clk);
    rd_chk("ready flags", csw_pkg::REG_STAT, 32'hC00, 32'hC00);
    `CHK("mid_stall", 1'b0, mid_stall)
    fast_lock <= 1'b0;
    wr(csw_pkg::REG_FREQ, 32'h5);
    rd_chk("ready flags", csw_pkg::REG_STAT, 32'hC00, 32'h0);
    `CHK("mid_stall", 1'b1, mid_stall)
    `CHK("freq_sel", 4'h5, freq_sel)
    repeat (130) @(posedge sys_clk);
    `CHK("mid_stall", 1'b1, mid_stall)
    rd_chk("mid only", csw_pkg::REG_STAT, 32'hC00, 32'h800);
    fast_lock <= 1'b1;
    repeat (130) @(posedge sys_clk);
    rd_chk("ready flags", csw_pkg::REG_STAT, 32'hC00, 32'hC00);
    `CHK("mid_stall", 1'b0, mid_stall)
    $display("test frequency done");

    wr(csw_pkg::REG_CTRL, 32'h6);
    rd_chk("ctrl", csw_pkg::REG_CTRL, 32'h7, 32'h6);
    osc_stable <= 6'h3F;
    foreach (src_list[i]) begin
      wr(csw_pkg::REG_REQ, {29'h0, src_list[i]});
      wait_src(src_list[i]);
      `CHK("src_sel", src_list[i], src_sel)
      `CHK("gate_en", 1'b0, gate_en)
      `CHK("irq", 1'b1, irq)
      rd_chk("cur src", csw_pkg::REG_STAT, 32'h7, {29'h0, src_list[i]});
      rd_chk("flag", csw_pkg::REG_FLAG, 32'h1, 32'h1);
      wr(csw_pkg::REG_FLAG, 32'h1);
      rd_chk("flag", csw_pkg::REG_FLAG, 32'h1, 32'h0);
      `CHK("irq", 1'b0, irq)
    end
    $display("test sources done");

    osc_stable <= 6'h00;
    wr(csw_pkg::REG_REQ, 32'h2);
    repeat (10) @(negedge sys_clk);
    `CHK("src_sel", 3'h1, src_sel)
    rd_chk("pending", csw_pkg::REG_STAT, 32'h300, 32'h0);
    sleep_req <= 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK("sleep_ack", 1'b1, sleep_ack)
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    osc_stable <= 6'h04;
    wait_src(3'h2);
    `CHK("src_sel", 3'h2, src_sel)
    rd_chk("idle ready", csw_pkg::REG_STAT, 32'h300, 32'h200);
    wr(csw_pkg::REG_FLAG, 32'h1);
    $display("test pending done");

    osc_stable <= 6'h3F;
    cpu_cycle <= 1'b1;
    wr(csw_pkg::REG_CTRL, 32'h3);
    wr(csw_pkg::REG_REQ, 32'h3);
    repeat (6) @(negedge sys_clk);
    rd_chk("held", csw_pkg::REG_STAT, 32'h307, 32'h302);
    `CHK("src_sel", 3'h2, src_sel)
    `CHK("irq", 1'b1, irq)
    wr(csw_pkg::REG_CTRL, 32'h2);
    wait_src(3'h3);
    `CHK("src_sel", 3'h3, src_sel)
    wr(csw_pkg::REG_FLAG, 32'h1);
    wr(csw_pkg::REG_CTRL, 32'h1);
    wr(csw_pkg::REG_REQ, 32'h5);
    repeat (6) @(negedge sys_clk);
    rd_chk("flag", csw_pkg::REG_FLAG, 32'h1, 32'h1);
    `CHK("irq", 1'b0, irq)
    wr(csw_pkg::REG_REQ, 32'h3);
    rd_chk("cancel", csw_pkg::REG_STAT, 32'h100, 32'h0);
    wr(csw_pkg::REG_CTRL, 32'h0);
    repeat (8) @(negedge sys_clk);
    `CHK("src_sel", 3'h3, src_sel)
    wr(csw_pkg::REG_FLAG, 32'h1);
    $display("test hold done");

    osc_stable <= 6'h00;
    cpu_cycle <= 1'b0;
    wr(csw_pkg::REG_REQ, 32'h73);
    repeat (8) @(negedge sys_clk);
    rd_chk("div ready", csw_pkg::REG_STAT, 32'h1F7, 32'h103);
    `CHK("div_sel", 4'h0, div_sel)
    @(posedge sys_clk);
    cpu_cycle <= 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("div_sel", 4'h7, div_sel)
    wr(csw_pkg::REG_STAT, 32'h0);
    rd_chk("cur field", csw_pkg::REG_STAT, 32'hF7, 32'h73);
    $display("test divider done");
    wrap_up();
  end
endmodule
